// File: design/oss_pkg.sv
package oss_pkg;

   // Pin synchroniser depth
   localparam int SYNC_STAGES = 2;

   // Channel count and divider width
   localparam int NUM_CHAN = 3;
   localparam int DIV_W = 8;

   // System clock period and missing-clock threshold
   localparam int CLK_PERIOD_NS = 10;
   localparam int MISS_TIME_NS = 10000;
   // Longest time, rounds down
   localparam int MISS_CYCLES = MISS_TIME_NS / CLK_PERIOD_NS;
   localparam int GAP_W = 11;
   localparam logic [GAP_W-1:0] MISS_COUNT = GAP_W'(MISS_CYCLES);

   // Dead interval between opposite switches
   localparam int DEAD_CYCLES = 2;
   localparam int DEAD_W = 2;

   // Reset values
   localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;
   localparam logic [1:0] SLEW_SR0 = 2'h0;
   localparam logic [1:0] SLEW_SR1 = 2'h1;
   localparam logic [1:0] SLEW_SR2 = 2'h2;
   localparam logic [1:0] SLEW_RESET = SLEW_SR0;

   // Half-bridge sequencing states
   typedef enum logic [2:0] {
      OSS_OFF = 3'b000,
      OSS_DEAD_TO_DRV = 3'b001,
      OSS_DRIVE = 3'b010,
      OSS_DEAD_TO_REC = 3'b011,
      OSS_RECIRC = 3'b100
   } oss_chan_state_t;

endpackage : oss_pkg

// File: design/oss_half_bridge.sv
`timescale 1ns/1ps
`default_nettype none

module oss_half_bridge
   import oss_pkg::*;
#(
   parameter int DEAD = DEAD_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   // Control
   input wire logic chan_on,
   input wire logic low_side,
   input wire logic drive_req,
   // Gates
   output logic hs_gate_q,
   output logic ls_gate_q
);

   oss_chan_state_t state_q, state_d;
   logic [DEAD_W-1:0] dead_q;
   logic role_q;
   logic drv_d, rec_d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      case (state_q)
         OSS_OFF: begin
            if (chan_on) begin
               state_d = drive_req ? OSS_DEAD_TO_DRV : OSS_DEAD_TO_REC;
            end
         end
         OSS_DEAD_TO_DRV: begin
            if (dead_q == DEAD_W'(DEAD - 1)) begin
               state_d = OSS_DRIVE;
            end
         end
         OSS_DRIVE: begin
            if (!drive_req) begin
               state_d = OSS_DEAD_TO_REC;
            end
         end
         OSS_DEAD_TO_REC: begin
            if (dead_q == DEAD_W'(DEAD - 1)) begin
               state_d = OSS_RECIRC;
            end
         end
         OSS_RECIRC: begin
            if (drive_req) begin
               state_d = OSS_DEAD_TO_DRV;
            end
         end
         default: state_d = OSS_OFF;
      endcase
      // Role change mid-cycle would swap live gates, so fall back to off
      if (!chan_on || low_side != role_q) begin
         state_d = OSS_OFF;
      end
   end

   // Only one state drives each role, so both can never be on together
   assign drv_d = (state_d == OSS_DRIVE);
   assign rec_d = (state_d == OSS_RECIRC);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= OSS_OFF;
         dead_q <= '0;
         role_q <= 1'b0;
         hs_gate_q <= 1'b0;
         ls_gate_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         role_q <= low_side;
         dead_q <= (state_d != state_q) ? '0 : dead_q + 1'b1;
         hs_gate_q <= low_side ? rec_d : drv_d;
         ls_gate_q <= low_side ? drv_d : rec_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_no_shoot_through: assert property (
      @(posedge clk_sys) disable iff (rst) !(hs_gate_q && ls_gate_q))
      else $error("both switches of one bridge on");

   a_disabled_bridge_off: assert property (
      @(posedge clk_sys) disable iff (rst)
      (clk_en && !chan_on) |=> (!hs_gate_q && !ls_gate_q))
      else $error("disabled bridge not high impedance");

   a_dead_gap_held: assert property (
      @(posedge clk_sys) disable iff (rst)
      ($fell(hs_gate_q) || $fell(ls_gate_q)) |-> !(hs_gate_q || ls_gate_q))
      else $error("opposite switch turned on without dead gap");

   c_bridge_drive: cover property (@(posedge clk_sys) disable iff (rst) $rose(drv_d));

endmodule : oss_half_bridge

`default_nettype wire

// File: design/oss_supervisor.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - System tick divides external clock by ratio plus one
// - Outputs off until divider ratio written
// - Missing clock when edge gap exceeds threshold
// - Watchdog starts off; host sets enable
// - Outputs off while watchdog not enabled
// - Missing clock: status, fault, off, reset
// - Locked: every frame answers version read
// - Enable low: channels off, masked fault
// - Enable low clears setpoint enable bits
// - Reset pin low: reset, fault, ignore
// - Fault low on diagnosis or reset
// - Disabled channel: both switches off
// - Low-side drives low, high-side drives high
// - Drive pulses; recirculate while drive off
// - Never drive and recirculate together
// - Strap low high-side, high low-side; readable
// - Host selects one of three slews
// - Three independent channels
// - Missing threshold at most ten microseconds

module oss_supervisor
   import oss_pkg::*;
#(
   parameter int CHANS = NUM_CHAN,
   parameter int DIVW = DIV_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   // Device pins
   input wire logic ext_clk_pin,
   input wire logic reset_in_low,
   input wire logic enable_pin,
   input wire logic [CHANS-1:0] side_select_strap,
   // Clock divider register write
   input wire logic div_wr,
   input wire logic [DIVW-1:0] div_ratio,
   input wire logic clock_watchdog_enable,
   // Configuration register write
   input wire logic cfg_wr,
   input wire logic [1:0] cfg_slew,
   input wire logic fault_mask_enable,
   // Setpoint enable write
   input wire logic sp_wr,
   input wire logic [CHANS-1:0] sp_chan_en,
   // Current loop and diagnosis
   input wire logic [CHANS-1:0] drive_req,
   input wire logic [CHANS-1:0] diag_fault,
   // Open-drain fault pin
   output logic fault_out_low_o,
   output logic fault_out_low_oe,
   // Gate drive
   output logic [CHANS-1:0] hs_gate_q,
   output logic [CHANS-1:0] ls_gate_q,
   // Status
   output logic sys_tick_q,
   output logic wdog_status_q,
   output logic version_only_q,
   output logic spi_ignore_q,
   output logic div_written_q,
   output logic wdog_enabled_q,
   output logic [CHANS-1:0] role_low_side_q,
   output logic [1:0] slew_q,
   output logic [CHANS-1:0] chan_en_q
);

   localparam int NPIN = CHANS + 3;

   logic [NPIN-1:0] meta_q, sync_q;
   logic clk_s, reset_in_low_s, en_s;
   logic [CHANS-1:0] strap_s;
   logic int_rst;
   logic clk_prev_q, clk_rise;
   logic [GAP_W-1:0] gap_q;
   logic lock_q;
   logic miss;
   logic [DIVW-1:0] ratio_q, div_cnt_q;
   logic allow;
   logic fault_pull_d;
   logic [CHANS-1:0] bridge_on;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser; first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (clk_en) begin
         meta_q <= {side_select_strap, enable_pin, reset_in_low, ext_clk_pin};
         sync_q <= meta_q;
      end
   end

   assign clk_s = sync_q[0];
   assign reset_in_low_s = sync_q[1];
   assign en_s = sync_q[2];
   assign strap_s = sync_q[NPIN-1:3];

   // Reset pin holds the core in reset; synchroniser, fault pin, version_only_q and spi_ignore_q use rst only
   assign int_rst = rst || !reset_in_low_s;

   ////////////////////////////////////////////////////////////////////////////
   // Clock divider
   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         ratio_q <= DIVW'(DIV_RESET);
         div_written_q <= 1'b0;
         wdog_enabled_q <= 1'b0;
      end else if (clk_en && div_wr && !lock_q) begin
         ratio_q <= div_ratio;
         div_written_q <= 1'b1;
         wdog_enabled_q <= clock_watchdog_enable;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         div_cnt_q <= '0;
         sys_tick_q <= 1'b0;
      end else if (clk_en) begin
         if (clk_rise) begin
            sys_tick_q <= (div_cnt_q >= ratio_q);
            div_cnt_q <= (div_cnt_q >= ratio_q) ? '0 : div_cnt_q + 1'b1;
         end else begin
            sys_tick_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Missing-clock watchdog
   assign clk_rise = clk_s && !clk_prev_q;
   // Gap equal to the rounded-down count already exceeds the threshold
   assign miss = wdog_enabled_q && (gap_q >= MISS_COUNT);

   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         clk_prev_q <= 1'b0;
         gap_q <= '0;
      end else if (clk_en) begin
         clk_prev_q <= clk_s;
         if (clk_rise) begin
            gap_q <= '0;
         end else if (gap_q < MISS_COUNT) begin
            gap_q <= gap_q + 1'b1;
         end
      end
   end

   // Lock is sticky; soft writes cannot clear it, only rst or the reset pin
   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         lock_q <= 1'b0;
         wdog_status_q <= 1'b0;
      end else if (clk_en && miss) begin
         lock_q <= 1'b1;
         wdog_status_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         version_only_q <= 1'b0;
         spi_ignore_q <= 1'b1;
      end else if (clk_en) begin
         version_only_q <= lock_q || miss;
         spi_ignore_q <= !reset_in_low_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration and setpoint enables
   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         slew_q <= SLEW_RESET;
         role_low_side_q <= '0;
      end else if (clk_en) begin
         role_low_side_q <= strap_s;
         // Unused fourth code keeps the previous setting
         if (cfg_wr && !lock_q && cfg_slew != 2'h3) begin
            slew_q <= cfg_slew;
         end
      end
   end

   // Enable pin low beats a simultaneous host write
   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         chan_en_q <= '0;
      end else if (clk_en) begin
         if (!en_s || lock_q) begin
            chan_en_q <= '0;
         end else if (sp_wr) begin
            chan_en_q <= sp_chan_en;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output gating and fault pin
   assign allow = div_written_q && wdog_enabled_q && !lock_q && !miss && en_s;
   assign bridge_on = allow ? chan_en_q : '0;
   assign fault_pull_d = int_rst || lock_q || miss || (|diag_fault)
                         || (!en_s && fault_mask_enable);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fault_out_low_o <= 1'b0;
         fault_out_low_oe <= 1'b1;
      end else if (clk_en) begin
         fault_out_low_o <= 1'b0;
         fault_out_low_oe <= fault_pull_d;
      end
   end

   for (genvar i = 0; i < CHANS; i++) begin : g_chan
      oss_half_bridge u_bridge (
         .clk_sys(clk_sys),
         .rst(int_rst),
         .clk_en(clk_en),
         .chan_on(bridge_on[i]),
         .low_side(role_low_side_q[i]),
         .drive_req(drive_req[i]),
         .hs_gate_q(hs_gate_q[i]),
         .ls_gate_q(ls_gate_q[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_lock_kills_gates: assert property (
      (clk_en && lock_q) |=> (hs_gate_q == '0 && ls_gate_q == '0))
      else $error("gates on while locked");

   a_lock_sticky_pin: assert property (
      (lock_q && reset_in_low_s && clk_en) |=> lock_q)
      else $error("lock left without reset pin");

   a_fault_on_lock: assert property (
      (clk_en && miss) |=> fault_out_low_oe && wdog_status_q)
      else $error("missing clock did not flag fault");

   a_miss_gap_bound: assert property (
      (wdog_enabled_q && !lock_q && clk_en [*8]) |-> !(gap_q > MISS_COUNT))
      else $error("gap counter passed threshold");

   a_no_div_no_out: assert property (
      (!div_written_q || !wdog_enabled_q) |=> ##1 (hs_gate_q == '0 && ls_gate_q == '0))
      else $error("gates on before divider or watchdog set");

   a_enable_clears_sp: assert property (
      (clk_en && !en_s) |=> (chan_en_q == '0))
      else $error("setpoint enables kept with enable low");

   a_pin_reset_fault: assert property (
      (clk_en && !reset_in_low_s) |=> fault_out_low_oe && spi_ignore_q)
      else $error("reset pin low without fault or spi ignore");

   a_pin_reset_clears: assert property (
      (!reset_in_low_s) |=> (!div_written_q && !wdog_enabled_q && !lock_q))
      else $error("reset pin low left core state set");

   a_div_write_lands: assert property (
      (clk_en && div_wr && !lock_q && !int_rst)
      |=> (div_written_q && ratio_q == $past(div_ratio)))
      else $error("divider write not taken");

   a_tick_after_rise: assert property (
      $rose(sys_tick_q) |-> $past(clk_rise && clk_en))
      else $error("system tick without external clock rise");

   a_strap_role: assert property (
      (clk_en && !int_rst) |=> (role_low_side_q == $past(strap_s)))
      else $error("readable role does not follow strap");

   a_slew_code_held: assert property (
      (clk_en && cfg_wr && cfg_slew == 2'h3 && !int_rst) |=> $stable(slew_q))
      else $error("unused slew code changed setting");

   a_masked_fault_pin: assert property (
      (clk_en && !en_s && fault_mask_enable) |=> fault_out_low_oe)
      else $error("masked enable low did not pull fault");

   a_enable_low_gates: assert property (
      (clk_en && !en_s) |=> (hs_gate_q == '0 && ls_gate_q == '0))
      else $error("gates on with enable low");

   a_version_when_lock: assert property (
      (clk_en && lock_q) |=> version_only_q)
      else $error("locked without version-only answer");

   c_lock_entered: cover property ($rose(lock_q));
   c_masked_fault: cover property (!en_s && fault_mask_enable ##1 fault_out_low_oe);
   c_all_on: cover property (bridge_on == '1);

endmodule : oss_supervisor

`default_nettype wire

// File: sim/oss_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module oss_host_model #(
   parameter int HALF = 4
) (
   // Clock and control
   input wire logic clk_sys,
   input wire logic run,
   // Device fault pin
   input wire logic fault_out_low_o,
   input wire logic fault_out_low_oe,
   output wire logic fault_pin,
   // External clock
   output var logic ext_clk_pin,
   output var int gap_cyc
);
   int ph;

   initial begin
      ext_clk_pin = 1'b0;
      gap_cyc = 0;
      ph = 0;
   end

   ////////////////////////////////////////////////////////////////
   // Pull-up resistor on the open-drain line
   assign fault_pin = fault_out_low_oe ? fault_out_low_o : 1'b1;

   ////////////////////////////////////////////////////////////////
   // Clock source; pulled down when stopped, gap counts from last rise
   always @(negedge clk_sys) begin
      gap_cyc <= gap_cyc + 1;
      if (!run) begin
         ext_clk_pin <= 1'b0;
         ph <= 0;
      end else if (ph == HALF - 1) begin
         ph <= 0;
         ext_clk_pin <= ~ext_clk_pin;
         if (!ext_clk_pin) begin
            gap_cyc <= 0;
         end
      end else begin
         ph <= ph + 1;
      end
   end
endmodule : oss_host_model

`default_nettype wire

// File: sim/output_stage_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none

module output_stage_supervisor_bench;
   import oss_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, reset_in_low = 1'b1, enable_pin = 1'b1, run = 1'b0;
   logic div_wr = 1'b0, wd_en = 1'b0, cfg_wr = 1'b0, fault_mask = 1'b0, sp_wr = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] ratio = 8'h00;
   logic [1:0] slew_in = 2'h0, slew_q;
   logic [2:0] strap = 3'h5, sp_en = 3'h0, drive_req = 3'h0, diag = 3'h0;
   logic [2:0] hs, ls, role, chan_en, hs_p1 = 3'h0, hs_p2 = 3'h0, ls_p1 = 3'h0, ls_p2 = 3'h0;
   logic ext_clk, fault_o, fault_oe, fault_pin, tick, wst, vonly, sig, divw, wde;
   int gap_cyc, g, exp_slew;
   logic [7:0] ratios [3] = '{8'h00, 8'h01, 8'h03};
   integer err_count = 0, n_tests = 0, seed = 59642;

   oss_supervisor i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .ext_clk_pin(ext_clk),
      .reset_in_low(reset_in_low), .enable_pin(enable_pin), .side_select_strap(strap),
      .div_wr(div_wr), .div_ratio(ratio), .clock_watchdog_enable(wd_en), .cfg_wr(cfg_wr),
      .cfg_slew(slew_in), .fault_mask_enable(fault_mask), .sp_wr(sp_wr), .sp_chan_en(sp_en),
      .drive_req(drive_req), .diag_fault(diag), .fault_out_low_o(fault_o),
      .fault_out_low_oe(fault_oe), .hs_gate_q(hs), .ls_gate_q(ls), .sys_tick_q(tick),
      .wdog_status_q(wst), .version_only_q(vonly), .spi_ignore_q(sig), .div_written_q(divw),
      .wdog_enabled_q(wde), .role_low_side_q(role), .slew_q(slew_q), .chan_en_q(chan_en));

   oss_host_model #(.HALF(4)) i_host (.clk_sys(clk_sys), .run(run), .fault_out_low_o(fault_o),
      .fault_out_low_oe(fault_oe), .fault_pin(fault_pin), .ext_clk_pin(ext_clk),
      .gap_cyc(gap_cyc));

   ////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   initial begin
      #200000;
      err_count++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////
   // Tasks
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   // Kind 0 divider, 1 configuration, 2 setpoint enables
   task automatic wr(input int k, input logic [7:0] v, input logic e);
      @(negedge clk_sys);
      ratio = v;
      wd_en = e;
      slew_in = v[1:0];
      sp_en = v[2:0];
      div_wr = (k == 0);
      cfg_wr = (k == 1);
      sp_wr = (k == 2);
      @(negedge clk_sys);
      div_wr = 1'b0;
      cfg_wr = 1'b0;
      sp_wr = 1'b0;
   endtask : wr

   // Cycles between two ticks, bounded
   task automatic tick_gap(output int n);
      int i;
      n = 0;
      for (i = 0; i < 300 && tick !== 1'b1; i++) @(negedge clk_sys);
      @(negedge clk_sys);
      n = 1;
      while (tick !== 1'b1 && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
   endtask : tick_gap

   task automatic stop_test;
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////
   // Gate monitor; dead time seen as opposite gate low for the two cycles before a rise
   always @(negedge clk_sys) begin
      if (!rst) begin
         chk("shoot_through", 8'h00, {5'h00, hs & ls});
         chk("dead_hs", 8'h00, {5'h00, hs & ~hs_p1 & (ls_p1 | ls_p2)});
         chk("dead_ls", 8'h00, {5'h00, ls & ~ls_p1 & (hs_p1 | hs_p2)});
      end
      hs_p1 <= hs;
      hs_p2 <= hs_p1;
      ls_p1 <= ls;
      ls_p2 <= ls_p1;
   end

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      cyc(3);
      chk("gates_rst", 8'h00, {2'h0, hs, ls});
      chk("fault_rst", 8'h00, {7'h00, fault_pin});
      chk("ignore_rst", 8'h01, {7'h00, sig});
      cyc(2);
      rst = 1'b0;
      run = 1'b1;
      cyc(6);
      chk("wdog_start", 8'h00, {6'h00, divw, wde});
      chk("fault_idle", 8'h01, {7'h00, fault_pin});
      drive_req = 3'h7;
      wr(2, 8'h07, 1'b0);
      cyc(10);
      chk("gates_nodiv", 8'h00, {2'h0, hs, ls});
      wr(0, 8'h02, 1'b0);
      cyc(10);
      chk("gates_nowdog", 8'h00, {2'h0, hs, ls});
      wr(0, 8'h02, 1'b1);
      cyc(8);
      chk("role", {5'h00, strap}, {5'h00, role});
      chk("drive", {2'h0, ~strap, strap}, {2'h0, hs, ls});
      drive_req = 3'h0;
      cyc(8);
      chk("recirc", {2'h0, strap, ~strap}, {2'h0, hs, ls});
      // Tick spacing is ratio+1 external periods of 8 cycles
      foreach (ratios[i]) begin
         wr(0, ratios[i], 1'b1);
         tick_gap(g);
         tick_gap(g);
         chk("tick_gap", 8'((ratios[i] + 1) * 8), 8'(g));
      end
      repeat (300) begin
         @(negedge clk_sys);
         drive_req = 3'($random(seed));
      end
      wr(2, 8'h02, 1'b0);
      cyc(4);
      chk("off_chan", 8'h00, {5'h00, (hs | ls) & 3'h5});
      exp_slew = 0;
      for (int s = 0; s < 4; s++) begin
         wr(1, 8'(s), 1'b0);
         cyc(2);
         exp_slew = (s < 3) ? s : exp_slew;
         chk("slew", 8'(exp_slew), {6'h00, slew_q});
      end
      // Clock enable low must freeze the slew register
      clk_en = 1'b0;
      wr(1, 8'h00, 1'b0);
      cyc(2);
      chk("frozen_slew", 8'(exp_slew), {6'h00, slew_q});
      clk_en = 1'b1;
      enable_pin = 1'b0;
      cyc(6);
      chk("en_clear", 8'h00, {5'h00, chan_en});
      chk("en_gates", 8'h00, {2'h0, hs, ls});
      chk("en_nomask", 8'h01, {7'h00, fault_pin});
      wr(1, 8'h01, 1'b0);
      cyc(2);
      chk("en_spi", 8'h01, {6'h00, slew_q});
      fault_mask = 1'b1;
      cyc(3);
      chk("en_mask", 8'h00, {7'h00, fault_pin});
      enable_pin = 1'b1;
      fault_mask = 1'b0;
      diag = 3'h4;
      cyc(6);
      chk("diag", 8'h00, {7'h00, fault_pin});
      diag = 3'h0;
      wr(0, 8'h00, 1'b0);
      run = 1'b0;
      cyc(1100);
      chk("no_wdog", 8'h00, {7'h00, vonly});
      run = 1'b1;
      // Stale gap would trip at once; let a clock rise pass first
      cyc(20);
      wr(0, 8'h00, 1'b1);
      wr(2, 8'h07, 1'b0);
      drive_req = 3'h7;
      cyc(20);
      run = 1'b0;
      for (int i = 0; i < 1100 && vonly !== 1'b1; i++) @(negedge clk_sys);
      chk("miss_time", 8'h01, {7'h00, gap_cyc >= 1000 && gap_cyc <= 1006});
      cyc(2);
      chk("lock", 8'h03, {6'h00, wst, fault_pin ^ 1'b1});
      chk("lock_gates", 8'h00, {2'h0, hs, ls});
      run = 1'b1;
      wr(0, 8'h02, 1'b1);
      cyc(20);
      chk("locked", 8'h01, {7'h00, vonly});
      reset_in_low = 1'b0;
      cyc(5);
      chk("reset_in_low_low", 8'h02, {6'h00, sig, fault_pin});
      wr(0, 8'h02, 1'b1);
      reset_in_low = 1'b1;
      cyc(6);
      chk("reset_in_low_ignore", 8'h00, {7'h00, divw});
      chk("released", 8'h00, {6'h00, vonly, wst});
      stop_test();
   end
endmodule : output_stage_supervisor_bench

`default_nettype wire
